// ---- hw/ast_defs.svh ----
`ifndef AST_DEFS_SVH
`define AST_DEFS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define AST_OFF_CTRL 4'h0
`define AST_OFF_DATA0 4'h4
`define AST_OFF_DATA1 4'h8
`define AST_OFF_DATA2 4'hc

// ----------------------------------------
// Control/status field positions
// ----------------------------------------
`define AST_B_MST 3
`define AST_B_WL 4
`define AST_B_DIR 6
`define AST_B_LRS 7
`define AST_B_CKP 8
`define AST_B_REL 9
`define AST_B_DWE 10
`define AST_B_IE 11
`define AST_B_IL 12
`define AST_CTRL_RESET 13'h0000

// ----------------------------------------
// Word length codes and vectors
// ----------------------------------------
`define AST_WL_16 2'h0
`define AST_WL_24 2'h1
`define AST_WL_32 2'h2
`define AST_TOP_BIT 6'h17
`define AST_EXP_BITS 6'h08
`define AST_VEC_L0 8'h10
`define AST_VEC_R0 8'h12
`define AST_VEC_X0 8'h14
`define AST_VEC_L1 8'h40
`define AST_VEC_R1 8'h42
`define AST_VEC_X1 8'h44

// ----------------------------------------
// Timing
// ----------------------------------------
`define AST_CORE_CLK_NS 20
`define AST_BCLK_NS 160
`define AST_HALF_CYCLES (`AST_BCLK_NS / (2 * `AST_CORE_CLK_NS))

`endif

// ---- hw/ast_pkg.sv ----
package ast_pkg;
	typedef logic [23:0] ast_word_t;
	typedef enum logic [2:0]
	{
		st_idle = 3'b001,
		st_seek = 3'b010,
		st_shift = 3'b100
	} ast_state_t;
endpackage

// ---- hw/ast_lane_if.sv ----
interface ast_lane_if;
	logic change;
	logic ws_sync;
	logic sck_level;
	logic master;
	logic ckp;
	logic run;
	logic load;
	logic shifting;
	logic dwe;
	logic dir;
	logic [5:0] idx;
	logic [1:0] wl;
	modport gen (input master, ckp, run, output change, ws_sync, sck_level);
	modport ctrl (input change, ws_sync, sck_level,
		output master, ckp, run, load, shifting, dwe, dir, idx, wl);
	modport lane (input change, run, load, shifting, dwe, dir, idx, wl);
endinterface

// ---- hw/ast_bitgen.sv ----
`include "ast_defs.svh"

module ast_bitgen (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Raw link pins
	input wire logic sck_pin,
	input wire logic ws_pin,
	// Shared strobes
	ast_lane_if.gen lif
);
	logic [1:0] sck_sync;
	logic [1:0] ws_sync_r;
	logic sck_prev;
	logic [7:0] half_cnt;
	logic gen_sck;

	wire half_done = (half_cnt == 8'(`AST_HALF_CYCLES - 1));
	wire slave_rise = sck_sync[1] & ~sck_prev;
	wire slave_fall = ~sck_sync[1] & sck_prev;
	wire slave_change = lif.ckp ? slave_rise : slave_fall;
	wire master_change = lif.run & half_done & ((~gen_sck) == lif.ckp);

	assign lif.sck_level = gen_sck;

	always_ff @(posedge core_clk)
	begin
		sck_sync <= {sck_sync[0], sck_pin};
		ws_sync_r <= {ws_sync_r[0], ws_pin};
		sck_prev <= sck_sync[1];
		lif.ws_sync <= ws_sync_r[1];
		lif.change <= rst ? 1'b0 : (lif.master ? master_change : slave_change);
	end

	// Idle level is the one opposite the change edge, so the first toggle launches bit 0
	always_ff @(posedge core_clk)
	begin
		if (rst || !lif.run)
		begin
			half_cnt <= 8'h00;
			gen_sck <= ~lif.ckp;
		end
		else if (half_done)
		begin
			half_cnt <= 8'h00;
			gen_sck <= ~gen_sck;
		end
		else
			half_cnt <= half_cnt + 8'h01;
	end
endmodule // ast_bitgen

// ---- hw/ast_shifter.sv ----
`include "ast_defs.svh"

module ast_shifter (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Lane data
	input wire logic enable,
	input wire ast_pkg::ast_word_t data,
	ast_lane_if.lane lif,
	// Serial output
	output logic sdo
);
	ast_pkg::ast_word_t sreg;

	function automatic logic pick(input ast_pkg::ast_word_t w, input logic [5:0] idx,
		input logic [1:0] wl, input logic dwe, input logic dir);
		logic [5:0] k;
		logic [5:0] pos;
		k = idx;
		if (wl == `AST_WL_32)
			k = dwe ? ((idx < `AST_EXP_BITS) ? 6'h00 : idx - `AST_EXP_BITS)
				: ((idx > `AST_TOP_BIT) ? `AST_TOP_BIT : idx);
		if (wl == `AST_WL_16)
			pos = dir ? k + `AST_EXP_BITS : `AST_TOP_BIT - k;
		else
			pos = dir ? k : `AST_TOP_BIT - k;
		return w[pos[4:0]];
	endfunction

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			sreg <= 24'h000000;
			sdo <= 1'b1;
		end
		else
		begin
			if (!enable || !lif.run)
				sdo <= 1'b1;
			else if (lif.change && lif.shifting)
				sdo <= pick(lif.load ? data : sreg, lif.idx, lif.wl, lif.dwe, lif.dir);
			if (lif.change && lif.load)
				sreg <= data;
		end
	end

	AST_DISABLED_HIGH: assert property (@(posedge core_clk) disable iff (rst)
		!enable |=> sdo) else $error("disabled lane not high");
endmodule // ast_shifter

// ---- hw/ast_tx.sv ----
// Added by the designer: the address map and the Avalon-MM register port.
`include "ast_defs.svh"

// Operation
// - Word select low marks left, high right; polarity bit inverts; cleared on reset.
// - Clock polarity bit picks which bit-clock edge launches word select and data.
// - Early-timing bit moves word select change one bit before first data bit.
// - 32-bit, no expansion: send 24 data bits, then last bit eight more times.
// - 32-bit with expansion: first bit eight times, then the full 24-bit word.
// - Expansion bit ignored unless word length is 32 bits.
// - Interrupt enable set: request while either empty flag set; flags always update.
// - Clearing interrupt enable masks a pending request two cycles later.
// - Vectors: left for left-empty only, right for right-empty only, exception both.
// - Vector location bit chooses 10/12/14 or 40/42/44 hexadecimal addresses.
// - Writing all enabled data registers clears the single set flag and request.
// - On underrun, flags clear only after status read then data writes.
// - On underrun, stale data register contents are sent again.
// - All lanes run in lockstep; flags reflect every enabled data register.
// - Left-empty sets when right words move into the shift registers.
// - Right-empty sets when left words move into the shift registers.
// - Flags forced clear by resets, stop and all lanes disabled.
// - Status bit 13 is reserved and reads zero.
// - Each 24-bit data register copies to its shifter after the last bit.
// - After enabling, the first word sent is the left word.
// - Word length code selects 16, 24 or 32 bit clocks; code 3 reserved.
// - Master mode drives bit clock and word select; slave mode takes them.
// - A disabled lane holds its serial output high.
// - Direction bit chooses most or least significant bit first.
module ast_tx (
	// Clock and resets
	input wire logic core_clk,
	input wire logic rst,
	input wire logic soft_reset,
	input wire logic stop_mode,
	// Avalon-MM slave
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Serial link
	input wire logic tx_bit_clock_in,
	output logic tx_bit_clock_out,
	output logic tx_bit_clock_oe,
	input wire logic tx_word_select_in,
	output logic tx_word_select_out,
	output logic tx_word_select_oe,
	output logic [2:0] serial_data_out,
	// Interrupt request
	output logic tx_irq_request,
	output logic [7:0] tx_irq_vector
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	logic [12:0] ctrl;
	logic lde;
	logic rde;
	logic ie_d;
	logic indiv_reset;
	logic status_seen;
	logic [2:0] wr_mask;
	ast_pkg::ast_word_t data_reg [0:2];
	ast_pkg::ast_state_t state;
	ast_pkg::ast_state_t next_state;
	logic side;
	logic armed;
	logic prev_side;
	logic ws_out;
	logic [5:0] cnt;

	ast_lane_if lif ();

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] lane_mask(input logic [3:0] be);
		return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
	endfunction

	function automatic logic match(input logic ws, input logic prev, input logic want);
		return (ws != prev) && (ws == want);
	endfunction

	function automatic logic [5:0] word_bits(input logic [1:0] wl);
		case (wl)
			`AST_WL_16: return 6'h10;
			`AST_WL_24: return 6'h18;
			default: return 6'h20;
		endcase
	endfunction

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	wire [2:0] en = ctrl[2:0];
	wire master = ctrl[`AST_B_MST];
	wire lrs = ctrl[`AST_B_LRS];
	wire rel = ctrl[`AST_B_REL];
	wire il = ctrl[`AST_B_IL];
	wire [1:0] wl = ctrl[`AST_B_WL +: 2];
	wire idle = stop_mode | indiv_reset;
	wire force_clr = soft_reset | idle;
	wire rd_take = avs_read & ~avs_waitrequest;
	wire wr_take = avs_write & ~avs_waitrequest;
	wire [31:0] be_mask = lane_mask(avs_byteenable);
	wire hit_ctrl = (avs_address == `AST_OFF_CTRL);
	wire [2:0] hit_data = {avs_address == `AST_OFF_DATA2, avs_address == `AST_OFF_DATA1,
		avs_address == `AST_OFF_DATA0};
	wire [2:0] wr_hit = hit_data & {3{wr_take}};
	wire [2:0] mask_now = wr_mask | wr_hit;
	wire all_written = (|en) & ((mask_now & en) == en);
	wire normal = lde ^ rde;
	wire under = lde & rde;
	wire clear_fire = all_written & (normal | (under & status_seen));
	wire [5:0] wl_bits = word_bits(wl);
	wire dwe_eff = ctrl[`AST_B_DWE] & (wl == `AST_WL_32);
	wire ws_side = lif.ws_sync ^ lrs;
	wire in_seek = (state == ast_pkg::st_seek);
	wire in_shift = (state == ast_pkg::st_shift);
	// Mid-word edges are never looked at, only the one expected next
	wire start = lif.change & in_seek
		& (master | (rel ? armed : match(ws_side, prev_side, side)));
	wire last = lif.change & in_shift & (cnt == wl_bits - 6'h01);
	wire arm_now = rel & ~master & ((last & match(ws_side, prev_side, ~side))
		| (lif.change & in_seek & ~armed & match(ws_side, prev_side, side)));
	wire set_l = start & side;
	wire set_r = start & ~side;
	wire next_lde = ~force_clr & (set_l | (lde & ~clear_fire));
	wire next_rde = ~force_clr & (set_r | (rde & ~clear_fire));
	wire next_seen = ~force_clr & ~clear_fire
		& (status_seen | (rd_take & hit_ctrl & under));
	wire [7:0] vec_sel = under ? (il ? `AST_VEC_X1 : `AST_VEC_X0)
		: lde ? (il ? `AST_VEC_L1 : `AST_VEC_L0)
		: rde ? (il ? `AST_VEC_R1 : `AST_VEC_R0) : 8'h00;
	wire [31:0] read_word = hit_ctrl ? {16'h0000, rde, lde, 1'b0, ctrl} : 32'h00000000;

	// ----------------------------------------
	// Lane strobes and pins
	// ----------------------------------------
	assign lif.master = master;
	assign lif.ckp = ctrl[`AST_B_CKP];
	assign lif.run = ~idle;
	assign lif.load = start;
	assign lif.shifting = start | in_shift;
	assign lif.idx = start ? 6'h00 : cnt;
	assign lif.wl = wl;
	assign lif.dwe = dwe_eff;
	assign lif.dir = ctrl[`AST_B_DIR];
	assign tx_bit_clock_out = lif.sck_level;
	assign tx_bit_clock_oe = master;
	assign tx_word_select_out = ws_out;
	assign tx_word_select_oe = master;

	ast_bitgen u_bitgen (
		.core_clk(core_clk),
		.rst(rst),
		.sck_pin(tx_bit_clock_in),
		.ws_pin(tx_word_select_in),
		.lif(lif)
	);

	for (genvar i = 0; i < 3; i++)
	begin : g_lane
		ast_shifter u_lane (
			.core_clk(core_clk),
			.rst(rst),
			.enable(en[i]),
			.data(data_reg[i]),
			.lif(lif),
			.sdo(serial_data_out[i])
		);
	end

	// ----------------------------------------
	// Register bus
	// ----------------------------------------
	// One wait cycle per access keeps read data registered
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h00000000;
		end
		else
		begin
			avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
			if (avs_read && avs_waitrequest)
				avs_readdata <= read_word;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (rst || soft_reset)
			ctrl <= `AST_CTRL_RESET;
		else if (wr_take && hit_ctrl)
			ctrl <= (ctrl & ~be_mask[12:0]) | (avs_writedata[12:0] & be_mask[12:0]);
	end

	// Data survives transfers, so an underrun replays the old sample
	always_ff @(posedge core_clk)
	begin
		for (int i = 0; i < 3; i++)
		begin
			if (rst)
				data_reg[i] <= 24'h000000;
			else if (wr_hit[i])
				data_reg[i] <= (data_reg[i] & ~be_mask[23:0])
					| (avs_writedata[23:0] & be_mask[23:0]);
		end
	end

	// ----------------------------------------
	// Flags and interrupt request
	// ----------------------------------------
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			lde <= 1'b0;
			rde <= 1'b0;
			status_seen <= 1'b0;
			wr_mask <= 3'h0;
		end
		else
		begin
			lde <= next_lde;
			rde <= next_rde;
			status_seen <= next_seen;
			// Underrun counts only the writes that follow the status read
			wr_mask <= (force_clr | clear_fire | start | (rd_take & hit_ctrl & under))
				? 3'h0 : mask_now;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			indiv_reset <= 1'b1;
			ie_d <= 1'b0;
			tx_irq_request <= 1'b0;
			tx_irq_vector <= 8'h00;
		end
		else
		begin
			indiv_reset <= ~|en;
			ie_d <= ctrl[`AST_B_IE];
			tx_irq_request <= ie_d & (lde | rde);
			tx_irq_vector <= vec_sel;
		end
	end

	// ----------------------------------------
	// Word controller
	// ----------------------------------------
	always_comb
	begin
		next_state = state;
		case (state)
			ast_pkg::st_idle: if (!idle) next_state = ast_pkg::st_seek;
			ast_pkg::st_seek:
				if (idle)
					next_state = ast_pkg::st_idle;
				else if (start)
					next_state = ast_pkg::st_shift;
			ast_pkg::st_shift:
				if (idle)
					next_state = ast_pkg::st_idle;
				else if (last)
					next_state = ast_pkg::st_seek;
			default: next_state = ast_pkg::st_idle;
		endcase
	end

	always_ff @(posedge core_clk)
	begin
		if (rst || soft_reset || idle)
		begin
			state <= rst ? ast_pkg::st_idle : next_state;
			side <= 1'b0;
			armed <= 1'b0;
			cnt <= 6'h00;
			prev_side <= 1'b0;
		end
		else
		begin
			state <= next_state;
			armed <= ~start & (armed | arm_now);
			if (last)
				side <= ~side;
			if (lif.change)
			begin
				prev_side <= ws_side;
				cnt <= start ? 6'h01 : (in_shift ? cnt + 6'h01 : cnt);
			end
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (rst || soft_reset)
			ws_out <= 1'b0;
		else if (idle)
			ws_out <= lrs;
		else if (master && start && !rel)
			ws_out <= side ^ lrs;
		else if (master && last && rel)
			ws_out <= ~side ^ lrs;
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);

	AST_WS_POLARITY: assert property (master && !rel && in_shift
		|-> tx_word_select_out == (side ^ lrs)) else $error("word select level wrong");
	AST_REL_EARLY: assert property (master && rel && last && !idle && !soft_reset
		|=> tx_word_select_out != $past(tx_word_select_out)) else $error("early edge missing");
	AST_RSV_ZERO: assert property (rd_take
		|-> !avs_readdata[13] && avs_readdata[31:16] == 16'h0000) else $error("reserved bit set");
	AST_SET_LDE: assert property (set_l && !force_clr |=> lde)
		else $error("left empty not set");
	AST_SET_RDE: assert property (set_r && !force_clr |=> rde)
		else $error("right empty not set");
	AST_IRQ: assert property (ctrl[`AST_B_IE] && (lde || rde) ##1 (lde || rde)
		|=> tx_irq_request) else $error("request missing");
	AST_IE_DELAY: assert property ($fell(ctrl[`AST_B_IE]) && (lde || rde) && !soft_reset
		|=> tx_irq_request ##1 !tx_irq_request) else $error("mask delay wrong");
	AST_VECTOR: assert property (under |=> tx_irq_vector ==
		($past(il) ? `AST_VEC_X1 : `AST_VEC_X0)) else $error("exception vector wrong");
	AST_CLEAR: assert property (clear_fire && normal && !start && !soft_reset
		|=> !lde && !rde) else $error("flag not cleared");
	AST_UNDER_HOLD: assert property (under && !status_seen && !force_clr
		&& !(rd_take && hit_ctrl) |=> under) else $error("underrun cleared early");
	AST_IDLE_CLR: assert property (force_clr |=> !lde && !rde)
		else $error("flags survive idle");
	AST_FIRST_LEFT: assert property (state == ast_pkg::st_idle && !idle && !soft_reset
		|=> in_seek && !side) else $error("first word not left");

	COV_UNDERRUN: cover property (under && status_seen ##[1:50] clear_fire);
	COV_NORMAL_CLEAR: cover property (clear_fire && normal);
	COV_SLAVE_EARLY: cover property (start && !master && rel);
endmodule // ast_tx

// ---- verification/ast_codec_model.sv ----
module ast_codec_model (
	// Wire levels seen on the link
	input wire logic sck,
	input wire logic ws,
	input wire logic sdo,
	// Setup from the bench
	input wire logic ckp,
	input wire logic rel,
	input wire logic run,
	input wire logic flush,
	input wire logic [5:0] len,
	// Clock and word select made in slave mode
	output logic sck_gen,
	output logic ws_gen,
	// Last whole word seen
	output logic [31:0] word,
	output logic [5:0] wlen,
	output logic wlev,
	output int wcnt
);
	timeunit 1ns;
	timeprecision 1ns;
	logic skp, wsd, wsw, wsp;
	logic [31:0] sr;
	logic [5:0] n, cnt;

	// --------------------
	// Slave-mode clock
	// --------------------
	// Stands still at its high idle level while run is low
	initial
	begin
		sck_gen = 1'b1;
		ws_gen = 1'b1;
		cnt = 6'h00;
		n = 6'h00;
		wcnt = 0;
		skp = 1'b1;
		#7;
		forever
		begin
			#80;
			if (run || !sck_gen)
				sck_gen = ~sck_gen;
		end
	end

	always @(negedge sck_gen)
	begin
		if (cnt == 6'h00)
			ws_gen = ~ws_gen;
		cnt = (cnt == len - 6'h01) ? 6'h00 : cnt + 6'h01;
	end

	// --------------------
	// Receiver
	// --------------------
	// Early word select is realigned by one sample
	always @(sck, flush, ws)
	begin
		if (flush)
		begin
			n = 6'h00;
			wsd = ws;
		end
		else if (sck !== skp && sck === !ckp)
		begin
			wsw = rel ? wsd : ws;
			if (n != 6'h00 && wsw !== wsp)
			begin
				word = sr;
				wlen = n;
				wlev = wsp;
				wcnt++;
				n = 6'h00;
			end
			sr = (n == 6'h00) ? {31'h0, sdo} : {sr[30:0], sdo};
			n++;
			wsp = wsw;
			wsd = ws;
		end
		skp = sck;
	end
endmodule // ast_codec_model

// ---- verification/test_audio_serial_transmitter.sv ----
`include "ast_defs.svh"

module test_audio_serial_transmitter;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk, rst, soft_reset, stop_mode, avs_read, avs_write, avs_waitrequest;
	logic [3:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, q, word;
	logic sck_o, sck_oe, ws_o, ws_oe, irq, sck_g, ws_g, run, flush, wlev;
	logic [2:0] sdo;
	logic [7:0] vec;
	logic [15:0] cfg;
	logic [5:0] wlen;
	logic [15:0] fmts [5] = '{16'h001d, 16'h040d, 16'h002d, 16'h042d, 16'h03dd};
	wire logic sck_w = sck_oe ? sck_o : sck_g;
	wire logic ws_w = ws_oe ? ws_o : ws_g;
	int wcnt, err_total, compares, k;

	ast_tx ast_tx_i (
		.core_clk(core_clk),
		.rst(rst),
		.soft_reset(soft_reset),
		.stop_mode(stop_mode),
		.avs_address(avs_address),
		.avs_read(avs_read),
		.avs_write(avs_write),
		.avs_writedata(avs_writedata),
		.avs_byteenable(4'hf),
		.avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest),
		.tx_bit_clock_in(sck_w),
		.tx_bit_clock_out(sck_o),
		.tx_bit_clock_oe(sck_oe),
		.tx_word_select_in(ws_w),
		.tx_word_select_out(ws_o),
		.tx_word_select_oe(ws_oe),
		.serial_data_out(sdo),
		.tx_irq_request(irq),
		.tx_irq_vector(vec)
	);

	ast_codec_model ast_codec_model_i (
		.sck(sck_w),
		.ws(ws_w),
		.sdo(sdo[0]),
		.ckp(cfg[8]),
		.rel(cfg[9]),
		.run(run),
		.flush(flush),
		.len(6'h10 + {1'b0, cfg[5:4], 3'h0}),
		.sck_gen(sck_g),
		.ws_gen(ws_g),
		.word(word),
		.wlen(wlen),
		.wlev(wlev),
		.wcnt(wcnt)
	);

	initial
	begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end

	// --------------------
	// Checking and bus tasks
	// --------------------
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e)
		begin
			err_total++;
			$display("mismatch at %0t: seen %h expected %h", $time, s, e);
		end
	endtask

	task automatic wrap_up;
		$display("comparisons %0d, mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic stuck;
		chk(32'h0, 32'h1);
		wrap_up();
	endtask

	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		do
		begin
			@(posedge core_clk);
			n++;
		end
		while (avs_waitrequest !== 1'b0 && n < 20);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		if (avs_waitrequest !== 1'b0)
			stuck();
		@(posedge core_clk);
	endtask

	task automatic wdata(input logic [23:0] d);
		for (int i = 1; i < 4; i++)
			bus(1'b1, {i[1:0], 2'b00}, {8'h00, d});
	endtask

	// Mode 0 word count, 1 vector equal, 2 vector moved away
	task automatic till(input int sel, input int v);
		int n;
		n = 0;
		while (n < 3000 && (sel == 0 ? wcnt < v : (sel == 1) == (vec !== v[7:0])))
		begin
			@(posedge core_clk);
			n++;
		end
		if (n >= 3000)
			stuck();
	endtask

	task automatic setup(input logic [15:0] c, input logic [23:0] d);
		// Stop the lanes first: format bits change only in individual reset
		bus(1'b1, `AST_OFF_CTRL, {16'h0000, cfg & 16'hfff8});
		cfg = c;
		bus(1'b1, `AST_OFF_CTRL, {16'h0000, c & 16'hfff8});
		flush <= 1'b1;
		wdata(d);
		flush <= 1'b0;
		chk(sck_o, !c[8]);
		k = wcnt;
		bus(1'b1, `AST_OFF_CTRL, {16'h0000, c});
	endtask

	task automatic frame(input logic [15:0] c, input logic [23:0] d);
		logic [23:0] r;
		logic [31:0] e;
		r = d;
		if (c[6])
			r = {<<{d}};
		case (c[5:4])
			2'h0: e = {16'h0000, d[23:8]};
			2'h1: e = {8'h00, r};
			default: e = c[10] ? {{8{r[23]}}, r} : {r, {8{r[0]}}};
		endcase
		setup(c, d);
		till(0, k + 1);
		chk(word, e);
		chk(wlen, 6'h10 + {1'b0, c[5:4], 3'h0});
		chk(wlev, c[7]);
		chk({sck_oe, ws_oe, sdo[2:1]}, {c[3], c[3], sdo[0], 1'b1});
	endtask

	// --------------------
	// Main sequence
	// --------------------
	initial
	begin
		rst = 1'b1;
		soft_reset = 1'b0;
		stop_mode = 1'b0;
		avs_address = 4'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		run = 1'b0;
		flush = 1'b0;
		cfg = 16'h0000;
		err_total = 0;
		compares = 0;
		repeat (4) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		bus(1'b0, `AST_OFF_CTRL, 32'h0);
		chk(q, 32'h0);
		chk({irq, vec, sdo}, 12'h007);
		bus(1'b1, `AST_OFF_CTRL, 32'hffff_fff8);
		bus(1'b0, `AST_OFF_CTRL, 32'h0);
		chk(q, 32'h0000_1ff8);
		bus(1'b0, 4'h2, 32'h0);
		chk(q, 32'h0);
		// Lanes 0 and 2 on, master, every format
		foreach (fmts[i])
			frame(fmts[i], 24'hc3a51e);
		// Alternate left and right loads, then starve
		setup(16'h081d, 24'h111111);
		till(1, 32'h12);
		chk(irq, 1'b1);
		wdata(24'h222222);
		till(1, 32'h0);
		chk(irq, 1'b0);
		till(1, 32'h10);
		wdata(24'h333333);
		till(1, 32'h12);
		till(1, 32'h14);
		till(0, k + 4);
		chk(word, 32'h0033_3333);
		wdata(24'h444444);
		chk(vec, 8'h14);
		bus(1'b0, `AST_OFF_CTRL, 32'h0);
		chk(q[15:14], 2'b11);
		repeat (2) @(posedge core_clk);
		chk(vec, 8'h14);
		wdata(24'h444444);
		till(2, 32'h14);
		till(2, 32'h0);
		bus(1'b1, `AST_OFF_CTRL, 32'h0000_001d);
		chk(irq, 1'b1);
		repeat (3) @(posedge core_clk);
		chk(irq, 1'b0);
		bus(1'b0, `AST_OFF_CTRL, 32'h0);
		chk(q[15:14] != 2'b00, 1'b1);
		// Second vector bank, stop, disable, soft reset
		setup(16'h181d, 24'h555555);
		till(1, 32'h42);
		stop_mode <= 1'b1;
		till(1, 32'h0);
		stop_mode <= 1'b0;
		bus(1'b1, `AST_OFF_CTRL, 32'h0000_1818);
		bus(1'b0, `AST_OFF_CTRL, 32'h0);
		chk(q, 32'h0000_1818);
		soft_reset <= 1'b1;
		@(posedge core_clk);
		soft_reset <= 1'b0;
		bus(1'b0, `AST_OFF_CTRL, 32'h0);
		chk(q, 32'h0);
		// Slave: the codec makes clock and word select
		setup(16'h0815, 24'h666666);
		run <= 1'b1;
		till(1, 32'h12);
		chk({sck_oe, ws_oe}, 2'b00);
		run <= 1'b0;
		wrap_up();
	end
endmodule // test_audio_serial_transmitter
